// ===== verilog/cil_cfg.svh
`ifndef CIL_CFG_SVH
`define CIL_CFG_SVH
`define CIL_VECTOR_ADDR 15'h0004
`define CIL_PC_RESET 15'h0000
`define CIL_STATUS_TO_BIT 4
`define CIL_STATUS_PD_BIT 3
`define CIL_PIR_WIDTH 8
`define CIL_PCHG_WIDTH 8
`endif

// ===== verilog/cil_pkg.sv
`include "cil_cfg.svh"
package cil_pkg;
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [4:0] bank_select_reg;
        logic [15:0] fsr0;
        logic [15:0] fsr1;
        logic [6:0] pc_high_latch;
    } cil_ctx_t;
    typedef enum logic [3:0] {
        CIL_RUN = 4'h1,
        CIL_FLUSH = 4'h2,
        CIL_VECTOR = 4'h4,
        CIL_WAKE = 4'h8
    } cil_state_t;
    typedef enum logic [3:0] {
        CIL_Q1 = 4'h1,
        CIL_Q2 = 4'h2,
        CIL_Q3 = 4'h4,
        CIL_Q4 = 4'h8
    } cil_phase_t;
endpackage : cil_pkg

// ===== verilog/cil_irq.sv
`include "cil_cfg.svh"
// How it works
// - Any reset clears every enable, so nothing vectors until software enables.
// - Request needs own enable, and group enable for peripheral sources; entry also needs global enable.
// - Flags set on their event regardless of any enable bit.
// - Entry flushes prefetch, clears global enable, pushes PC, loads vector 0004h.
// - Entry copies critical core registers into shadow registers.
// - Shadow holds W, status less timeout/power-down, bank, indirect, PC high latch.
// - Global enable clear: flags still set, no redirect; pending serviced later.
// - Return pops address, restores shadow context, sets global enable.
// - Latency 3-4 cycles synchronous, 3-5 asynchronous.
// - Latency independent of single or two-cycle current instruction.
// - External pin flag sampled by vectoring logic each Q1.
// - External pin flag may become set during Q4 to Q1.
// - Wake vectors if global enable set, else continues after sleep.
// - Instruction after sleep always executes before handler branch.
// - External pin is an edge source enabled only by its pin enable.
// - Edge select set picks rising edge, clear picks falling edge.
// - Selected edge sets pin flag; redirect if global and pin enables set.
// - Pin-change summary is read-only, clears when all pin-change flags clear.
module cil_irq #(
    parameter int PIR_W = `CIL_PIR_WIDTH,
    parameter int PCHG_W = `CIL_PCHG_WIDTH
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ext_pin,
    input wire logic sw_ctl_we,
    input wire logic sw_global_enable,
    input wire logic sw_peripheral_group_enable,
    input wire logic sw_ext_pin_irq_enable,
    input wire logic sw_ext_pin_edge_select,
    input wire logic sw_pin_change_enable,
    input wire logic [PIR_W-1:0] sw_peripheral_enable,
    input wire logic sw_flag_clr_we,
    input wire logic sw_ext_pin_flag_clr,
    input wire logic [PIR_W-1:0] sw_peripheral_flag_clr,
    input wire logic [PCHG_W-1:0] sw_pin_change_flag_clr,
    input wire logic [PIR_W-1:0] peripheral_event,
    input wire logic [PCHG_W-1:0] pin_change_event,
    input wire logic [14:0] core_pc,
    input wire cil_pkg::cil_ctx_t core_ctx,
    input wire logic core_sleeping,
    input wire logic core_wake_instr_done,
    input wire logic return_from_handler_instr,
    input wire logic [14:0] stack_top,
    output logic global_irq_enable,
    output logic peripheral_group_enable,
    output logic ext_pin_irq_enable,
    output logic ext_pin_edge_select,
    output logic ext_pin_irq_flag,
    output logic [PIR_W-1:0] peripheral_flag_reg1,
    output logic [PCHG_W-1:0] pin_change_flag_reg,
    output logic pin_change_summary_flag,
    output logic irq_request,
    output logic flush_prefetch,
    output logic stack_push,
    output logic [14:0] stack_push_data,
    output logic pc_load,
    output logic [14:0] pc_load_value,
    output logic ctx_restore,
    output cil_pkg::cil_ctx_t shadow_ctx,
    output logic wake,
    output cil_pkg::cil_phase_t phase
);
    import cil_pkg::*;

    // ==========================================================
    // Phase counter and external pin edge detect
    cil_phase_t next_phase;
    logic pin_prev, next_pin_prev;
    logic pin_armed, next_pin_armed;
    logic pin_edge;
    always_comb begin
        unique case (phase)
            CIL_Q1: next_phase = CIL_Q2;
            CIL_Q2: next_phase = CIL_Q3;
            CIL_Q3: next_phase = CIL_Q4;
            CIL_Q4: next_phase = CIL_Q1;
            default: next_phase = CIL_Q1;
        endcase
        next_pin_prev = ext_pin;
        // No edge in the first cycle after reset, pin_prev is not the pin yet
        next_pin_armed = 1'b1;
        // Rising when select set, falling when clear
        pin_edge = pin_armed & (ext_pin_edge_select ? (ext_pin & ~pin_prev) : (~ext_pin & pin_prev));
    end

    // ==========================================================
    // Enables and flags
    logic next_gie, next_peripheral_group_enable, next_ext_pin_irq_enable, next_ext_pin_edge_select, next_iocie, next_ext_pin_irq_flag, next_ioc_sum;
    logic iocie;
    logic [PIR_W-1:0] pie, next_pie, next_pir;
    logic [PCHG_W-1:0] next_pchg;
    logic pin_pend, next_pin_pend;
    logic take_entry;
    always_comb begin
        next_gie = global_irq_enable;
        next_peripheral_group_enable = peripheral_group_enable;
        next_ext_pin_irq_enable = ext_pin_irq_enable;
        next_ext_pin_edge_select = ext_pin_edge_select;
        next_iocie = iocie;
        next_pie = pie;
        if (sw_ctl_we) begin
            next_gie = sw_global_enable;
            next_peripheral_group_enable = sw_peripheral_group_enable;
            next_ext_pin_irq_enable = sw_ext_pin_irq_enable;
            next_ext_pin_edge_select = sw_ext_pin_edge_select;
            next_iocie = sw_pin_change_enable;
            next_pie = sw_peripheral_enable;
        end
        if (return_from_handler_instr) begin
            next_gie = 1'b1;
        end
        if (take_entry) begin
            next_gie = 1'b0;
        end
        // Set wins over a simultaneous clear
        next_ext_pin_irq_flag = ext_pin_irq_flag;
        next_pir = peripheral_flag_reg1;
        next_pchg = pin_change_flag_reg;
        if (sw_flag_clr_we) begin
            next_ext_pin_irq_flag = ext_pin_irq_flag & ~sw_ext_pin_flag_clr;
            next_pir = peripheral_flag_reg1 & ~sw_peripheral_flag_clr;
            next_pchg = pin_change_flag_reg & ~sw_pin_change_flag_clr;
        end
        // Pin flag may set in Q4 or Q1 only; an edge in Q2 or Q3 waits here
        next_pin_pend = pin_pend | pin_edge;
        if (next_pin_pend && (phase == CIL_Q4 || phase == CIL_Q1)) begin
            next_ext_pin_irq_flag = 1'b1;
            next_pin_pend = 1'b0;
        end
        next_pir = next_pir | peripheral_event;
        next_pchg = next_pchg | pin_change_event;
        next_ioc_sum = |next_pchg;
    end

    // ==========================================================
    // Vectoring sequencer
    cil_state_t state, next_state;
    logic req_level, sampled_req, next_sampled_req;
    logic next_irq_request, next_flush, next_push, next_pc_load, next_restore, next_wake;
    logic [14:0] next_push_data, next_pc_value;
    cil_ctx_t next_shadow;
    always_comb begin
        // Pin enable alone gates the pin source
        req_level = (ext_pin_irq_flag & ext_pin_irq_enable)
            | (pin_change_summary_flag & iocie)
            | (peripheral_group_enable & |(peripheral_flag_reg1 & pie));
        next_irq_request = req_level;
        // Sampled once per instruction cycle at Q1
        next_sampled_req = (phase == CIL_Q1) ? req_level : sampled_req;
        take_entry = 1'b0;
        next_state = state;
        next_flush = 1'b0;
        next_push = 1'b0;
        next_pc_load = 1'b0;
        next_restore = return_from_handler_instr;
        next_wake = 1'b0;
        next_push_data = stack_push_data;
        next_pc_value = pc_load_value;
        next_shadow = shadow_ctx;
        if (return_from_handler_instr) begin
            next_pc_load = 1'b1;
            next_pc_value = stack_top;
        end
        unique case (state)
            CIL_RUN: begin
                if (core_sleeping && req_level) begin
                    next_wake = 1'b1;
                    next_state = CIL_WAKE;
                end else if (!core_sleeping && sampled_req && global_irq_enable && phase == CIL_Q2) begin
                    // Decided on the fixed phase grid, not on instruction length
                    take_entry = 1'b1;
                    next_flush = 1'b1;
                    next_state = CIL_FLUSH;
                end
            end
            CIL_WAKE: begin
                // Following instruction completes before any branch
                if (core_wake_instr_done) begin
                    next_state = CIL_RUN;
                end
            end
            CIL_FLUSH: begin
                if (phase == CIL_Q4) begin
                    next_push = 1'b1;
                    next_push_data = core_pc;
                    next_shadow = core_ctx;
                    next_shadow.status[`CIL_STATUS_TO_BIT] = 1'b0;
                    next_shadow.status[`CIL_STATUS_PD_BIT] = 1'b0;
                    next_state = CIL_VECTOR;
                end
            end
            CIL_VECTOR: begin
                next_pc_load = 1'b1;
                next_pc_value = `CIL_VECTOR_ADDR;
                next_state = CIL_RUN;
            end
            default: next_state = CIL_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase <= CIL_Q1;
            pin_prev <= 1'b0;
            pin_armed <= 1'b0;
            pin_pend <= 1'b0;
            global_irq_enable <= 1'b0;
            peripheral_group_enable <= 1'b0;
            ext_pin_irq_enable <= 1'b0;
            ext_pin_edge_select <= 1'b1;
            iocie <= 1'b0;
            pie <= '0;
            ext_pin_irq_flag <= 1'b0;
            peripheral_flag_reg1 <= '0;
            pin_change_flag_reg <= '0;
            pin_change_summary_flag <= 1'b0;
            state <= CIL_RUN;
            sampled_req <= 1'b0;
            irq_request <= 1'b0;
            flush_prefetch <= 1'b0;
            stack_push <= 1'b0;
            stack_push_data <= `CIL_PC_RESET;
            pc_load <= 1'b0;
            pc_load_value <= `CIL_PC_RESET;
            ctx_restore <= 1'b0;
            shadow_ctx <= '0;
            wake <= 1'b0;
        end else begin
            phase <= next_phase;
            pin_prev <= next_pin_prev;
            pin_armed <= next_pin_armed;
            pin_pend <= next_pin_pend;
            global_irq_enable <= next_gie;
            peripheral_group_enable <= next_peripheral_group_enable;
            ext_pin_irq_enable <= next_ext_pin_irq_enable;
            ext_pin_edge_select <= next_ext_pin_edge_select;
            iocie <= next_iocie;
            pie <= next_pie;
            ext_pin_irq_flag <= next_ext_pin_irq_flag;
            peripheral_flag_reg1 <= next_pir;
            pin_change_flag_reg <= next_pchg;
            pin_change_summary_flag <= next_ioc_sum;
            state <= next_state;
            sampled_req <= next_sampled_req;
            irq_request <= next_irq_request;
            flush_prefetch <= next_flush;
            stack_push <= next_push;
            stack_push_data <= next_push_data;
            pc_load <= next_pc_load;
            pc_load_value <= next_pc_value;
            ctx_restore <= next_restore;
            shadow_ctx <= next_shadow;
            wake <= next_wake;
        end
    end

    // ==========================================================
    // Checks
    reset_enables_a: assert property (@(posedge clk_sys) $rose(resetn) |-> !global_irq_enable)
        else $error("global enable set after reset");
    entry_gating_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(flush_prefetch) |-> $past(global_irq_enable) && $past(sampled_req))
        else $error("entry without enables");
    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        peripheral_event != '0 |=> (peripheral_flag_reg1 & $past(peripheral_event)) == $past(peripheral_event))
        else $error("peripheral flag lost");
    entry_seq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(flush_prefetch) |-> !global_irq_enable ##[1:4] stack_push ##1 (pc_load && pc_load_value == 15'h0004))
        else $error("entry sequence broken");
    shadow_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        stack_push |-> !shadow_ctx.status[`CIL_STATUS_TO_BIT] && !shadow_ctx.status[`CIL_STATUS_PD_BIT])
        else $error("shadow kept timeout or power-down");
    no_redirect_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !global_irq_enable && !return_from_handler_instr && !sw_ctl_we |=> !$rose(flush_prefetch))
        else $error("redirect with global enable clear");
    return_gie_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        return_from_handler_instr && !take_entry |=> global_irq_enable && ctx_restore)
        else $error("return did not restore");
    summary_or_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        pin_change_summary_flag == (|pin_change_flag_reg))
        else $error("summary flag mismatch");

    // Entry grid, return and pin timing
    grid_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(flush_prefetch) |-> phase == CIL_Q3)
        else $error("entry off the phase grid");
    return_pop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        return_from_handler_instr && state != CIL_VECTOR |=> pc_load && pc_load_value == $past(stack_top))
        else $error("return did not pop the stack");
    pin_latched_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        pin_edge && !sw_flag_clr_we |-> ##[1:3] ext_pin_irq_flag)
        else $error("pin edge not latched");
    pin_window_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(ext_pin_irq_flag) |-> ($past(phase) == CIL_Q4 || $past(phase) == CIL_Q1))
        else $error("pin flag set outside Q4 to Q1");
endmodule : cil_irq

// ===== verification/cil_core_model.sv
module cil_core_model #(
    parameter cil_pkg::cil_ctx_t CTX = '0
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sleep_cmd,
    input wire logic stack_push,
    input wire logic [14:0] stack_push_data,
    input wire logic pc_load,
    input wire logic [14:0] pc_load_value,
    input wire logic ctx_restore,
    input wire cil_pkg::cil_ctx_t shadow_ctx,
    input wire logic wake,
    output logic [14:0] core_pc,
    output cil_pkg::cil_ctx_t core_ctx,
    output logic [14:0] stack_top,
    output logic core_sleeping,
    output logic core_wake_instr_done
);
    timeunit 1ns;
    timeprecision 1ns;
    import cil_pkg::*;
    logic [2:0] wake_cnt;
    // ====================
    // Core sequencer, moving between rising edges
    always @(negedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_pc <= 15'h0100;
            core_ctx <= CTX;
            stack_top <= 15'h0000;
            core_sleeping <= 1'b0;
            core_wake_instr_done <= 1'b0;
            wake_cnt <= 3'h0;
        end else begin
            core_pc <= pc_load ? pc_load_value : core_pc + 15'h0001;
            stack_top <= stack_push ? stack_push_data : stack_top;
            if (ctx_restore) begin
                core_ctx <= shadow_ctx;
            end else if (pc_load) begin
                // Handler clobbers W, so a missing restore shows
                core_ctx.w <= ~core_ctx.w;
            end
            core_sleeping <= wake ? 1'b0 : (sleep_cmd | core_sleeping);
            wake_cnt <= wake ? 3'h4 : (wake_cnt != 3'h0 ? wake_cnt - 3'h1 : 3'h0);
            core_wake_instr_done <= (wake_cnt == 3'h1);
        end
    end
endmodule : cil_core_model

// ===== verification/cil_irq_tb.sv
`include "cil_cfg.svh"
module cil_irq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cil_pkg::*;
    typedef struct packed {
        logic [12:0] ctl;
        logic [1:0] kind;
        logic [2:0] want;
    } cil_row_t;
    localparam cil_ctx_t CTX0 = '{8'h5a, 8'h1f, 5'h13, 16'h1234, 16'h5678, 7'h2b};
    // Kind: peripheral, rising pin, falling pin; want: flag, request, entry
    localparam cil_row_t ROWS [8] = '{'{13'h1a01, 2'h0, 3'h7}, '{13'h1201, 2'h0, 3'h4}, '{13'h1a00, 2'h0, 3'h4},
        '{13'h0a01, 2'h0, 3'h6}, '{13'h1600, 2'h1, 3'h7}, '{13'h1400, 2'h2, 3'h7}, '{13'h1a01, 2'h1, 3'h4},
        '{13'h1600, 2'h2, 3'h0}};
    logic clk_sys = 1'b0, resetn = 1'b1, ext_pin = 1'b0, sleep_cmd = 1'b0, ret = 1'b0;
    logic sw_ctl_we = 1'b0, sw_flag_clr_we = 1'b0;
    logic [12:0] ctl = 13'h0000;
    logic [16:0] clr_v = 17'h00000;
    logic [7:0] pir_ev = 8'h00, pchg_ev = 8'h00, peripheral_flag_reg1, pin_change_flag_reg;
    logic [14:0] core_pc, stack_top, stack_push_data, pc_load_value, ret_pc;
    cil_ctx_t core_ctx, shadow_ctx, exp_shadow;
    cil_phase_t phase;
    logic core_sleeping, core_wake_instr_done, global_irq_enable, peripheral_group_enable, ext_pin_irq_enable;
    logic ext_pin_edge_select, ext_pin_irq_flag, pin_change_summary_flag, irq_request, flush_prefetch;
    logic stack_push, pc_load, ctx_restore, wake;
    int errors = 0, n_compared = 0, cyc = 0, load_at = -1, done_at = -1, wake_at = -1, at, t0;

    cil_irq i_dut (.clk_sys, .resetn, .ext_pin, .sw_ctl_we, .sw_global_enable(ctl[12]),
        .sw_peripheral_group_enable(ctl[11]), .sw_ext_pin_irq_enable(ctl[10]), .sw_ext_pin_edge_select(ctl[9]),
        .sw_pin_change_enable(ctl[8]), .sw_peripheral_enable(ctl[7:0]), .sw_flag_clr_we,
        .sw_ext_pin_flag_clr(clr_v[16]), .sw_peripheral_flag_clr(clr_v[15:8]), .sw_pin_change_flag_clr(clr_v[7:0]),
        .peripheral_event(pir_ev), .pin_change_event(pchg_ev), .core_pc, .core_ctx, .core_sleeping,
        .core_wake_instr_done, .return_from_handler_instr(ret), .stack_top, .global_irq_enable,
        .peripheral_group_enable, .ext_pin_irq_enable, .ext_pin_edge_select, .ext_pin_irq_flag,
        .peripheral_flag_reg1, .pin_change_flag_reg, .pin_change_summary_flag, .irq_request, .flush_prefetch,
        .stack_push, .stack_push_data, .pc_load, .pc_load_value, .ctx_restore, .shadow_ctx, .wake, .phase);
    cil_core_model #(.CTX(CTX0)) i_core (.clk_sys, .resetn, .sleep_cmd, .stack_push, .stack_push_data, .pc_load,
        .pc_load_value, .ctx_restore, .shadow_ctx, .wake, .core_pc, .core_ctx, .stack_top, .core_sleeping,
        .core_wake_instr_done);

    always #50 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        if (pc_load === 1'b1) load_at = cyc;
        if (core_wake_instr_done === 1'b1) done_at = cyc;
        if (wake === 1'b1) wake_at = cyc;
        // Expected shadow is the core context at the push, less timeout and power-down
        if (stack_push === 1'b1) begin
            exp_shadow = core_ctx;
            exp_shadow.status[`CIL_STATUS_TO_BIT] = 1'b0;
            exp_shadow.status[`CIL_STATUS_PD_BIT] = 1'b0;
        end
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            $display("timeout");
            give_verdict();
        end
    end
    // ====================
    // Driving and checking tasks
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic wr_ctl(input logic [12:0] v);
        ctl = v;
        sw_ctl_we = 1'b1;
        tick(1);
        sw_ctl_we = 1'b0;
        tick(1);
    endtask : wr_ctl
    task automatic clr(input logic [16:0] v);
        clr_v = v;
        sw_flag_clr_we = 1'b1;
        tick(1);
        sw_flag_clr_we = 1'b0;
        tick(2);
    endtask : clr
    task automatic ev(input logic [7:0] p, input logic [7:0] c);
        pir_ev = p;
        pchg_ev = c;
        tick(1);
        pir_ev = 8'h00;
        pchg_ev = 8'h00;
        tick(2);
    endtask : ev
    task automatic wait_pc(input int n, input logic [14:0] exp);
        at = -1;
        for (int i = 0; i < n; i++) begin
            if (at < 0 && pc_load === 1'b1) begin
                at = i;
                chk("pc_value", exp, pc_load_value);
            end
            tick(1);
        end
    endtask : wait_pc
    task automatic rst_chk;
        chk("gie_rst", 0, global_irq_enable);
        chk("en_rst", 0, {peripheral_group_enable, ext_pin_irq_enable, irq_request});
        chk("edge_rst", 1, ext_pin_edge_select);
        chk("flag_rst", 0, ext_pin_irq_flag);
        $display("reset check done");
    endtask : rst_chk
    // ====================
    // Test sequence
    initial begin
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        tick(1);
        rst_chk();
        foreach (ROWS[r]) begin
            wr_ctl({3'h0, ROWS[r].ctl[9], 9'h000});
            ext_pin = (ROWS[r].kind == 2'h2);
            tick(8);
            clr(17'h1ffff);
            wr_ctl(ROWS[r].ctl);
            while (phase !== CIL_Q4) tick(1);
            // Pin moves in Q4 so the edge is taken
            if (ROWS[r].kind == 2'h0) ev(8'h01, 8'h00);
            else ext_pin = (ROWS[r].kind == 2'h1);
            wait_pc(20, 15'h0004);
            chk("entry", ROWS[r].want[0], at >= 0);
            chk("flag", ROWS[r].want[2], ROWS[r].kind == 2'h0 ? peripheral_flag_reg1[0] : ext_pin_irq_flag);
            chk("request", ROWS[r].want[1], irq_request);
            $display("row %0d done", r);
        end
        clr(17'h1ffff);
        wr_ctl(13'h0a01);
        ev(8'h01, 8'h00);
        wait_pc(20, 15'h0004);
        chk("held_off", 0, at >= 0);
        wr_ctl(13'h1a01);
        wait_pc(20, 15'h0004);
        chk("late_entry", 1, at >= 0);
        chk("shadow", exp_shadow, shadow_ctx);
        chk("gie_clear", 0, global_irq_enable);
        clr(17'h1ffff);
        ret_pc = stack_top;
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
        wait_pc(4, ret_pc);
        chk("return", 1, at >= 0);
        chk("gie_set", 1, global_irq_enable);
        chk("restore", exp_shadow, core_ctx);
        wait_pc(20, 15'h0004);
        chk("no_reentry", 0, at >= 0);
        $display("pending and return done");
        wr_ctl(13'h0b00);
        ev(8'h00, 8'h81);
        chk("sum_set", 2'b11, {pin_change_summary_flag, irq_request});
        clr(17'h00001);
        chk("sum_part", 1, pin_change_summary_flag);
        clr(17'h00080);
        tick(1);
        chk("sum_clr", 0, {pin_change_summary_flag, irq_request});
        $display("pin change done");
        // Edge in Q2 must still be latched once the window opens
        ext_pin = 1'b0;
        wr_ctl(13'h0600);
        clr(17'h1ffff);
        while (phase !== CIL_Q2) tick(1);
        ext_pin = 1'b1;
        tick(4);
        chk("pin_q2", 1, ext_pin_irq_flag);
        $display("pin window done");
        for (int g = 0; g < 2; g++) begin
            clr(17'h1ffff);
            wr_ctl({g[0], 12'ha01});
            sleep_cmd <= 1'b1;
            tick(1);
            sleep_cmd <= 1'b0;
            t0 = cyc;
            ev(8'h01, 8'h00);
            tick(24);
            chk("wake", 1, wake_at > t0);
            chk("vector_after_next", g, load_at > done_at && done_at > t0);
            $display("sleep case %0d done", g);
        end
        wr_ctl(13'h1fff);
        resetn = 1'b0;
        tick(1);
        resetn = 1'b1;
        tick(1);
        rst_chk();
        give_verdict();
    end
endmodule : cil_irq_tb
